// ===== hdl/pm_csr_pkg.sv
// Constants, types and field layout for the power management control/status bank
package pm_csr_pkg;

  // Field positions in the control/status word
  localparam int STAT_BIT = 15;
  localparam int SCALE_HI = 14;
  localparam int SCALE_LO = 13;
  localparam int SEL_HI = 12;
  localparam int SEL_LO = 9;
  localparam int WEN_BIT = 8;
  localparam int RSVD_HI = 7;
  localparam int RSVD_LO = 2;
  localparam int PST_HI = 1;
  localparam int PST_LO = 0;

  // Register choice on the configuration port
  localparam logic SEL_CSR = 1'b0;
  localparam logic SEL_PDATA = 1'b1;

  // Power state encodings as the host writes them
  localparam logic [1:0] PST_D0 = 2'h0;
  localparam logic [1:0] PST_D1 = 2'h1;
  localparam logic [1:0] PST_D2 = 2'h2;
  localparam logic [1:0] PST_D3 = 2'h3;

  // Scale codes: reserved, 0.1 W, 0.01 W, 0.001 W per count
  localparam logic [1:0] SCALE_RSVD = 2'h0;
  localparam logic [1:0] SCALE_100MW = 2'h1;
  localparam logic [1:0] SCALE_10MW = 2'h2;
  localparam logic [1:0] SCALE_1MW = 2'h3;

  // Select decode: bit 3 picks dissipated, bit 2 marks an empty slot
  localparam int SEL_DISS_BIT = 3;
  localparam int SEL_VOID_BIT = 2;

  // Reset values
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [1:0] REQ_RST = 2'h0;
  localparam logic [7:0] PDATA_RST = 8'h00;
  localparam logic [1:0] SCALE_RST = 2'h0;

  // Widths
  localparam int PDATA_W = 8;
  localparam int FIG_W = 10;
  localparam int FIG_DEPTH = 8;
  localparam int FIG_AW = 3;

  // One host access on the configuration port
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [1:0] be;
    logic [15:0] wdata;
  } cfg_req_t;

  // One entry of the power figure table: scale code over the data count
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] value;
  } power_fig_t;

  // Initialization write into the power figure table
  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    power_fig_t fig;
  } fig_init_t;

endpackage : pm_csr_pkg

// ===== hdl/power_fig_table.sv
// Small table holding the power figures and their scale codes
`timescale 1ns/1ps
module power_fig_table #(
  parameter int DEPTH = pm_csr_pkg::FIG_DEPTH,
  parameter int AW = pm_csr_pkg::FIG_AW
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Initialization load
  input wire pm_csr_pkg::fig_init_t init,
  // Lookup by select value
  input wire logic [3:0] sel,
  output pm_csr_pkg::power_fig_t fig
);
  import pm_csr_pkg::*;

  // Whole state: table entries plus registered read word
  typedef struct packed {
    power_fig_t [DEPTH-1:0] mem;
    power_fig_t rd;
  } fig_state_t;

  fig_state_t st_r;
  fig_state_t st_nxt;
  logic [AW-1:0] idx; // Entry index: consumed 0..3, dissipated 4..7

  // Drop the empty-slot bit so dissipated figures follow consumed ones
  assign idx = AW'({sel[SEL_DISS_BIT], sel[1:0]});

  // Next state: load on init, read out selected entry
  always_comb begin
    st_nxt = st_r;
    if (init.wr) begin
      st_nxt.mem[init.addr] = init.fig;
    end
    if (sel[SEL_VOID_BIT]) begin
      // Empty select slots give no figure and no scale
      st_nxt.rd = '0;
    end else begin
      st_nxt.rd = st_r.mem[idx];
    end
  end

  // Table contents are lost on reset and stay zero until rewritten through init
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fig = st_r.rd;

endmodule : power_fig_table

// ===== hdl/pm_csr.sv
// Power management control/status register bank with wake event logic
`timescale 1ns/1ps
module pm_csr (
  // Clock, bus reset and power-on reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic por,
  // Auxiliary supply present
  input wire logic aux_power_detect,
  // Host configuration access
  input wire pm_csr_pkg::cfg_req_t cfg_req,
  output logic [15:0] cfg_rdata,
  output logic cfg_ack,
  // Power figure initialization
  input wire pm_csr_pkg::fig_init_t fig_init,
  // DSP power management side
  input wire logic [1:0] dsp_current_state,
  output logic [1:0] dsp_requested_state,
  output logic dsp_pm_int,
  output logic dsp_warm_rst,
  // Wake event and open-drain wake pin
  input wire logic pm_event,
  output logic pme_n_out,
  output logic pme_oe
);
  import pm_csr_pkg::*;

  // Whole state of the bank
  typedef struct packed {
    logic stat;          // Sticky wake event status
    logic wen;           // Sticky wake assertion enable
    logic [3:0] sel;     // Power figure select
    logic [1:0] req;     // Requested state toward the DSP
    logic pm_int;        // One-cycle interrupt to the DSP
    logic warm_rst;      // One-cycle warm reset to the DSP
    logic ack;           // One-cycle access completion
    logic [15:0] rdata;  // Registered read word
  } csr_state_t;

  csr_state_t st_r;
  csr_state_t st_nxt;
  power_fig_t fig;          // Currently selected figure and scale
  logic [15:0] csr_word;    // Assembled control/status read value
  logic wr_csr;             // Write hitting the control/status word
  logic wr_lo;              // Low byte enabled
  logic wr_hi;              // High byte enabled
  logic [1:0] wr_pst;       // Written power state
  logic pst_legal;          // Written state is supported

  // Figure table sits on the select register
  power_fig_table #(
    .DEPTH(FIG_DEPTH),
    .AW(FIG_AW)
  ) u_fig (
    .ref_clk(ref_clk),
    .srst(srst | por),
    .init(fig_init),
    .sel(st_r.sel),
    .fig(fig)
  );

  // Write decode
  assign wr_csr = cfg_req.wr && (cfg_req.sel == SEL_CSR);
  assign wr_lo = wr_csr && cfg_req.be[0];
  assign wr_hi = wr_csr && cfg_req.be[1];
  assign wr_pst = cfg_req.wdata[PST_HI:PST_LO];
  // D1 and D2 are not offered, so only D0 and D3 pass
  assign pst_legal = (wr_pst == PST_D0) || (wr_pst == PST_D3);

  // Read word assembly
  always_comb begin
    csr_word = '0;
    csr_word[STAT_BIT] = st_r.stat;
    csr_word[SCALE_HI:SCALE_LO] = fig.scale;
    csr_word[SEL_HI:SEL_LO] = st_r.sel;
    csr_word[WEN_BIT] = st_r.wen;
    // State field shows where the DSP is, not what was asked for
    csr_word[PST_HI:PST_LO] = dsp_current_state;
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.pm_int = 1'b0;
    st_nxt.warm_rst = 1'b0;
    st_nxt.ack = 1'b0;
    if (srst) begin
      // Bus reset: sticky bits survive only on auxiliary power
      if (!aux_power_detect) begin
        st_nxt.stat = 1'b0;
        st_nxt.wen = 1'b0;
      end
      st_nxt.sel = SEL_RST;
      st_nxt.req = REQ_RST;
      st_nxt.rdata = '0;
    end else begin
      // Every access completes, legal or not
      st_nxt.ack = cfg_req.wr | cfg_req.rd;
      if (cfg_req.rd) begin
        if (cfg_req.sel == SEL_PDATA) begin
          st_nxt.rdata = {8'h00, fig.value};
        end else begin
          st_nxt.rdata = csr_word;
        end
      end
      if (wr_hi) begin
        st_nxt.sel = cfg_req.wdata[SEL_HI:SEL_LO];
        st_nxt.wen = cfg_req.wdata[WEN_BIT];
      end
      // Write-one clears, but an event in the same cycle still lands
      if (wr_hi && cfg_req.wdata[STAT_BIT]) begin
        st_nxt.stat = 1'b0;
      end
      if (pm_event) begin
        st_nxt.stat = 1'b1;
      end
      // Reserved bits 7..2 are not stored at all
      if (wr_lo && pst_legal && (wr_pst != st_r.req)) begin
        st_nxt.req = wr_pst;
        // Leaving D3 for D0 restarts the DSP; anything else interrupts
        if ((st_r.req == PST_D3) && (wr_pst == PST_D0)) begin
          st_nxt.warm_rst = 1'b1;
        end else begin
          st_nxt.pm_int = 1'b1;
        end
      end
      // Equal or unsupported requests fall through with no effect
    end
  end

  // Power-on reset clears everything, sticky bits included
  always_ff @(posedge ref_clk) begin
    if (por) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign cfg_rdata = st_r.rdata;
  assign cfg_ack = st_r.ack;
  assign dsp_requested_state = st_r.req;
  assign dsp_pm_int = st_r.pm_int;
  assign dsp_warm_rst = st_r.warm_rst;
  // Open-drain wake pin pulls low only while event and enable are both set
  assign pme_n_out = 1'b0;
  assign pme_oe = st_r.stat & st_r.wen;

endmodule : pm_csr

// ===== bench/pm_csr_sva.sv
// Port-level checks for the power management control/status bank
`timescale 1ns/1ps
module pm_csr_sva (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic por,
  // Host port
  input wire pm_csr_pkg::cfg_req_t cfg_req,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_ack,
  // DSP side and wake pin
  input wire logic [1:0] dsp_current_state,
  input wire logic [1:0] dsp_requested_state,
  input wire logic dsp_pm_int,
  input wire logic dsp_warm_rst,
  input wire logic pme_oe
);
  import pm_csr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst || por);
  // Byte-0 state write, word read and the written state value
  wire logic st_wr = cfg_req.wr && !cfg_req.sel && cfg_req.be[0];
  wire logic csr_rd = cfg_req.rd && !cfg_req.sel;
  wire logic [1:0] st_v = cfg_req.wdata[1:0];
  a_ack_follows: assert property ((cfg_req.wr || cfg_req.rd) |=> cfg_ack) else $error("access not acked");
  a_read_state: assert property (csr_rd |=> cfg_rdata[1:0] == $past(dsp_current_state))
    else $error("state field not current state");
  a_rsvd_zero: assert property (csr_rd |=> cfg_rdata[7:2] == 6'h00) else $error("reserved bits set");
  a_pdata_high: assert property (cfg_req.rd && cfg_req.sel |=> cfg_rdata[15:8] == 8'h00)
    else $error("power data upper byte set");
  a_req_update: assert property (st_wr && st_v[0] == st_v[1] && st_v != dsp_requested_state
    |=> dsp_requested_state == $past(st_v) && (dsp_pm_int ^ dsp_warm_rst)) else $error("request not taken");
  a_equal_quiet: assert property (st_wr && st_v == dsp_requested_state
    |=> !dsp_pm_int && !dsp_warm_rst && $stable(dsp_requested_state)) else $error("equal write signalled");
  a_illegal_quiet: assert property (st_wr && st_v[0] != st_v[1]
    |=> !dsp_pm_int && !dsp_warm_rst && $stable(dsp_requested_state)) else $error("unsupported state taken");
  // Wake stays asserted until a write clears or disables it
  a_pme_hold: assert property (pme_oe && !cfg_req.wr && !$past(cfg_req.wr) |=> pme_oe)
    else $error("wake dropped");
endmodule : pm_csr_sva
bind pm_csr pm_csr_sva chk (.*);

// ===== bench/dsp_pm_model.sv
// Behavioural DSP power manager that takes up each request after a delay
`timescale 1ns/1ps
module dsp_pm_model #(
  parameter int LAG = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Request in, reported state out
  input wire logic [1:0] dsp_requested_state,
  output logic [1:0] dsp_current_state
);
  // Cycles waited so far
  int wait_r;
  // A slow core: reported state lags the request by LAG+1 cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_r <= 0;
      dsp_current_state <= 2'h0;
    end else if (dsp_requested_state != dsp_current_state && wait_r < LAG) begin
      wait_r <= wait_r + 1;
    end else begin
      wait_r <= 0;
      dsp_current_state <= dsp_requested_state;
    end
  end
endmodule : dsp_pm_model

// ===== bench/tb.sv
// Self-checking bench for the power management control/status bank
`timescale 1ns/1ps
module tb;
  import pm_csr_pkg::*;
  // Promised answer of one access
  typedef struct packed {logic rd; logic [15:0] data; logic [3:0] dsp;} note_t;
  logic ref_clk, srst, por, aux_power_detect, pm_event, cfg_ack, dsp_pm_int, dsp_warm_rst, pme_n_out, pme_oe;
  logic [15:0] cfg_rdata;
  logic [1:0] dsp_current_state, dsp_requested_state;
  cfg_req_t cfg_req;
  fig_init_t fig_init;
  note_t notes[$];
  note_t got;
  power_fig_t figs [8];
  logic stat, wen;
  logic [3:0] sel;
  logic [1:0] req;
  logic [31:0] rnd;
  logic [1:0] seq [6] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h0, 2'h0};
  int err_total = 0, compares = 0, seed = 16, i;
  pm_csr uut (.*);
  dsp_pm_model far (.ref_clk(ref_clk), .srst(srst || por), .dsp_requested_state(dsp_requested_state),
    .dsp_current_state(dsp_current_state));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One access: strobe for one edge, promise noted first
  task automatic acc(input logic w, input logic s, input logic [1:0] be, input logic [15:0] wd, input note_t e);
    @(negedge ref_clk);
    notes.push_back(e);
    cfg_req = '{w, !w, s, be, wd};
    @(negedge ref_clk);
    cfg_req.wr = 1'b0;
    cfg_req.rd = 1'b0;
  endtask : acc
  task automatic rd_both;
    power_fig_t f;
    f = sel[2] ? 10'h000 : figs[{sel[3], sel[1:0]}];
    acc(1'b0, SEL_CSR, 2'h3, 16'h0000, '{1'b1, {stat, f.scale, sel, wen, 6'h00, req}, {req, 2'h0}});
    acc(1'b0, SEL_PDATA, 2'h3, 16'h0000, '{1'b1, {8'h00, f.value}, {req, 2'h0}});
  endtask : rd_both
  // Upper byte write; scale bits written as ones must not stick
  task automatic wr_hi(input logic clr, input logic w, input logic [3:0] s);
    acc(1'b1, SEL_CSR, 2'h2, {clr, 2'h3, s, w, 8'hff}, '{1'b0, 16'h0000, {req, 2'h0}});
    sel = s;
    wen = w;
    stat = stat & !clr;
  endtask : wr_hi
  task automatic pulse_event;
    @(negedge ref_clk);
    pm_event = 1'b1;
    @(negedge ref_clk);
    pm_event = 1'b0;
    stat = 1'b1;
  endtask : pulse_event
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Oldest note is checked whenever an access is acknowledged
  always @(negedge ref_clk) begin
    if (cfg_ack === 1'b1) begin
      got = notes.pop_front();
      if (got.rd) chk("read data", got.data, cfg_rdata);
      chk("dsp side", {12'h000, got.dsp}, {12'h000, dsp_requested_state, dsp_pm_int, dsp_warm_rst});
    end
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    report_and_stop;
  end
  initial begin
    {srst, por, aux_power_detect, pm_event, stat, wen, sel, req} = 12'he00;
    cfg_req = '0;
    fig_init = '0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    {srst, por} = 2'h0;
    // Random figures, scale codes cycled so every code shows
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      rnd = $random(seed);
      figs[i] = {i[1:0], rnd[7:0]};
      fig_init = '{1'b1, i[2:0], figs[i]};
    end
    @(negedge ref_clk);
    fig_init.wr = 1'b0;
    for (i = 0; i < 16; i++) begin
      wr_hi(1'b0, 1'b0, i[3:0]);
      rd_both;
    end
    // Power state writes with reserved bits set
    for (i = 0; i < 6; i++) begin
      acc(1'b1, SEL_CSR, 2'h1, {8'h00, 6'h3f, seq[i]}, '{1'b0, 16'h0000, {seq[i][0] == seq[i][1] ? seq[i] : req,
        seq[i][0] == seq[i][1] && seq[i] != req && !(req == PST_D3 && seq[i] == PST_D0), req == PST_D3 && seq[i] == PST_D0}});
      if (seq[i][0] == seq[i][1]) req = seq[i];
      repeat (8) @(negedge ref_clk);
      rd_both;
    end
    pulse_event;
    rd_both;
    chk("wake pin", 16'h0000, {15'h0000, pme_oe});
    wr_hi(1'b0, 1'b1, 4'h9);
    repeat (2) @(negedge ref_clk);
    chk("wake pin", 16'h0001, {15'h0000, pme_oe});
    chk("wake data", 16'h0000, {15'h0000, pme_n_out});
    rd_both;
    wr_hi(1'b1, 1'b1, 4'h9);
    rd_both;
    pulse_event;
    // Bus reset with aux present, without aux, then power-on reset
    for (i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      {aux_power_detect, srst, por} = {i != 1, i < 2, i == 2};
      @(negedge ref_clk);
      {srst, por, sel, req} = 'h0;
      figs = '{default: '0};
      if (i > 0) {stat, wen} = 2'h0;
      rd_both;
      if (i == 1) pulse_event;
    end
    report_and_stop;
  end
endmodule : tb
